// *** src/drce_deadtime.sv ***
// Replaceable dead-time correction of a factor-scaled pulse rate
`timescale 1ns/1ps
`default_nettype none

module drce_deadtime
  import drce_pkg::*;
(
  input  wire logic [47:0] scaled_rate,
  output logic      [47:0] correction
);

  logic [95:0] square;

  // Square-law loss model; swap this body for the real correction curve
  always_comb begin
    square     = scaled_rate * scaled_rate;
    correction = 48'(square / {48'h000000000000, DT_DIV});
  end

endmodule

`default_nettype wire

// *** src/drce_engine.sv ***
// Dose rate calibration engine: reading arithmetic and calibration control
//
// Behaviour
// - Hold sensitivity and two dead-time factors
// - Low range to 1000: second factor, divide 17
// - Low range over 1200: third factor, divide 17
// - Low range 1000-1200: blend by last reading
// - Mid range to 300: second factor, divide 300
// - Mid range over 400: third factor, divide 300
// - Mid range 300-400: blend by last reading
// - High range to 3500: second factor, divide 77
// - High range over 5500: third factor, divide 77
// - High range 3500-5500: blend by last reading
// - Reset press in calibration shows factors
// - Both buttons start factor setting display
// - Low range field picks editable factor
// - Mid range field picks editable factor
// - Buttons step enabled factor up or down
// - Factors kept 0.60-1.40 and stored
// - Switch off returns to measurement
// - Switch on enters calibration with indication
`timescale 1ns/1ps
`default_nettype none

module drce_engine
  import drce_pkg::*;
#(
  parameter drce_variant_e VARIANT     = VAR_LOW,
  parameter int unsigned   GATE_CYCLES = GATE_CYCLES_DEF
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire drce_pins_s    pins_i,
  input  wire drce_nvm_rsp_s nvm_i,
  output drce_nvm_req_s      nvm_o,
  output drce_disp_s         disp_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [3:0]      s1;
    logic [3:0]      s2;
    logic [3:0]      s3;
    logic [3:0]      lvl;
    logic [3:0]      lvl_d;
    drce_state_e     fsm;
    logic [31:0]     gate_cnt;
    logic [31:0]     pulse_cnt;
    logic [31:0]     freq;
    logic            calc_go;
    logic [31:0]     reading;
    logic [2:0][7:0] fac;
    logic [1:0]      show_idx;
    logic [1:0]      sel;
    logic [1:0]      load_idx;
    drce_nvm_req_s   nvm;
    drce_disp_s      disp;
  } drce_core_state_s;

  localparam drce_core_state_s ST_RST = '{
    fsm:     ST_LOAD,
    fac:     {FACTOR_RST, FACTOR_RST, FACTOR_RST},
    default: '0
  };

  localparam logic [31:0] GATE_LAST = 32'(GATE_CYCLES - 1);

  drce_core_state_s st_r;
  drce_core_state_s st_nxt;
  logic [7:0]       fdt;
  logic [47:0]      dt_in;
  logic [47:0]      dt_corr;
  logic [47:0]      sum;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [7:0] clamp_factor(input logic [7:0] f);
    if (f < FACTOR_MIN) begin
      return FACTOR_MIN;
    end else if (f > FACTOR_MAX) begin
      return FACTOR_MAX;
    end
    return f;
  endfunction

  function automatic logic [7:0] step_factor(input logic [7:0] f, input logic up);
    if (up) begin
      return (f >= FACTOR_MAX) ? FACTOR_MAX : clamp_factor(f + FACTOR_STEP);
    end
    return (f <= FACTOR_MIN) ? FACTOR_MIN : clamp_factor(f - FACTOR_STEP);
  endfunction

  function automatic logic [7:0] blend_factor(
    input logic [31:0]   last,
    input logic [7:0]    dt_lo,
    input logic [7:0]    dt_hi,
    input drce_variant_e v
  );
    logic [31:0]        lo;
    logic [31:0]        span;
    logic signed [40:0] diff;
    logic signed [40:0] pos;
    logic signed [40:0] w;
    lo   = BLEND_LO_LOW;
    span = BLEND_SPAN_LOW;
    w    = '0;
    case (v)
      VAR_MID: begin
        lo   = BLEND_LO_MID;
        span = BLEND_SPAN_MID;
      end
      VAR_HIGH: begin
        lo   = BLEND_LO_HIGH;
        span = BLEND_SPAN_HIGH;
      end
      default: begin
        lo   = BLEND_LO_LOW;
        span = BLEND_SPAN_LOW;
      end
    endcase
    diff = $signed({33'h000000000, dt_hi}) - $signed({33'h000000000, dt_lo});
    pos  = $signed({9'h000, last - lo});
    if (last <= lo) begin
      return dt_lo;
    end else if (last >= lo + span) begin
      return dt_hi;
    end
    w = (diff * pos) / $signed({9'h000, span});
    return 8'(w + $signed({33'h000000000, dt_lo}));
  endfunction

  function automatic logic [31:0] calc_reading(input logic [47:0] s, input drce_variant_e v);
    logic [47:0] scaled;
    logic [47:0] q;
    scaled = 48'(s * READ_MULT);
    case (v)
      VAR_MID:  q = scaled / DIV_MID;
      VAR_HIGH: q = scaled / DIV_HIGH;
      default:  q = scaled / DIV_LOW;
    endcase
    return (|q[47:32]) ? 32'hFFFFFFFF : q[31:0];
  endfunction

  function automatic logic [1:0] select_factor(input logic [31:0] r, input drce_variant_e v);
    logic [31:0] b1;
    logic [31:0] b2;
    logic [31:0] b3;
    case (v)
      VAR_MID: begin
        b1 = SEL1_MID;
        b2 = SEL2_MID;
        b3 = SEL3_MID;
      end
      VAR_HIGH: begin
        b1 = SEL1_HIGH;
        b2 = SEL2_HIGH;
        b3 = SEL3_HIGH;
      end
      default: begin
        b1 = SEL1_LOW;
        b2 = SEL2_LOW;
        b3 = SEL3_LOW;
      end
    endcase
    if (r > b3) begin
      return LBL_DT_HIGH;
    end else if (r > b2) begin
      return LBL_DT_LOW;
    end else if (r > b1) begin
      return LBL_SENS;
    end
    return LBL_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reading datapath
  assign fdt   = blend_factor(st_r.reading, st_r.fac[1], st_r.fac[2], VARIANT);
  assign dt_in = 48'({16'h0000, st_r.freq} * {40'h0000000000, fdt});

  drce_deadtime u_deadtime (
    .scaled_rate (dt_in),
    .correction  (dt_corr)
  );

  assign sum = 48'({16'h0000, st_r.freq} * {40'h0000000000, st_r.fac[0]}) + dt_corr;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [3:0] rise;
    logic [1:0] lbl;
    logic [1:0] idx;
    logic [7:0] nf;
    rise = '0;
    lbl  = LBL_NONE;
    idx  = '0;
    nf   = '0;

    st_nxt         = st_r;
    st_nxt.calc_go = 1'b0;
    st_nxt.nvm.we  = 1'b0;

    // Pin synchronisers with agreement filter
    st_nxt.s1    = pins_i;
    st_nxt.s2    = st_r.s1;
    st_nxt.s3    = st_r.s2;
    st_nxt.lvl   = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 | st_r.s3));
    st_nxt.lvl_d = st_r.lvl;
    rise         = st_r.lvl & ~st_r.lvl_d;

    // Frequency gate
    if (st_r.gate_cnt == GATE_LAST) begin
      st_nxt.gate_cnt  = '0;
      st_nxt.freq      = st_r.pulse_cnt + 32'(rise[IN_PULSE]);
      st_nxt.pulse_cnt = '0;
      st_nxt.calc_go   = 1'b1;
    end else begin
      st_nxt.gate_cnt = st_r.gate_cnt + 32'h00000001;
      if (rise[IN_PULSE]) begin
        st_nxt.pulse_cnt = st_r.pulse_cnt + 32'h00000001;
      end
    end

    if (st_r.calc_go) begin
      st_nxt.reading = calc_reading(sum, VARIANT);
    end

    // Controller
    case (st_r.fsm)
      ST_LOAD: begin
        st_nxt.nvm.rd_req = 1'b1;
        st_nxt.nvm.addr   = st_r.load_idx;
        if (st_r.nvm.rd_req && nvm_i.rd_valid) begin
          st_nxt.fac[st_r.load_idx] = clamp_factor(nvm_i.rd_data);
          st_nxt.nvm.rd_req         = 1'b0;
          if (st_r.load_idx == LOAD_LAST) begin
            st_nxt.fsm = ST_MEAS;
          end else begin
            st_nxt.load_idx = st_r.load_idx + 2'h1;
          end
        end
      end
      ST_MEAS: begin
        if (st_r.lvl[IN_CAL]) begin
          st_nxt.fsm      = ST_CAL;
          st_nxt.show_idx = LBL_NONE;
        end
      end
      ST_CAL: begin
        if (!st_r.lvl[IN_CAL]) begin
          st_nxt.fsm = ST_MEAS;
        end else if (st_r.lvl[IN_RESET] && st_r.lvl[IN_SPEAKER] &&
                     (rise[IN_RESET] || rise[IN_SPEAKER])) begin
          st_nxt.fsm = ST_SET;
          st_nxt.sel = select_factor(st_r.reading, VARIANT);
        end else if (rise[IN_RESET]) begin
          st_nxt.show_idx = st_r.show_idx + 2'h1;
        end
      end
      ST_SET: begin
        if (!st_r.lvl[IN_CAL]) begin
          st_nxt.fsm = ST_MEAS;
        end else begin
          if (st_r.calc_go) begin
            st_nxt.sel = select_factor(st_nxt.reading, VARIANT);
          end
          idx = 2'(st_r.sel - 2'h1);
          if (st_r.sel != LBL_NONE) begin
            if (rise[IN_RESET] && !st_r.lvl[IN_SPEAKER]) begin
              nf                = step_factor(st_r.fac[idx], 1'b1);
              st_nxt.fac[idx]   = nf;
              st_nxt.nvm.we     = 1'b1;
              st_nxt.nvm.addr   = idx;
              st_nxt.nvm.wdata  = nf;
            end else if (rise[IN_SPEAKER] && !st_r.lvl[IN_RESET]) begin
              nf                = step_factor(st_r.fac[idx], 1'b0);
              st_nxt.fac[idx]   = nf;
              st_nxt.nvm.we     = 1'b1;
              st_nxt.nvm.addr   = idx;
              st_nxt.nvm.wdata  = nf;
            end
          end
        end
      end
      default: begin
        st_nxt.fsm = ST_LOAD;
      end
    endcase

    // Display image
    if (st_nxt.fsm == ST_SET) begin
      lbl = st_nxt.sel;
    end else if (st_nxt.fsm == ST_CAL) begin
      lbl = st_nxt.show_idx;
    end
    st_nxt.disp.cal_ind  = (st_nxt.fsm == ST_CAL) || (st_nxt.fsm == ST_SET);
    st_nxt.disp.set_mode = (st_nxt.fsm == ST_SET);
    st_nxt.disp.label    = lbl;
    st_nxt.disp.factor   = (lbl == LBL_NONE) ? 8'h00 : st_nxt.fac[2'(lbl - 2'h1)];
    st_nxt.disp.reading  = st_nxt.reading;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign nvm_o  = st_r.nvm;
  assign disp_o = st_r.disp;

endmodule

`default_nettype wire

// *** src/drce_pkg.sv ***
// Constants, types and carriers of the dose rate calibration engine
package drce_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Product variant and controller states
  typedef enum logic [1:0] {
    VAR_LOW  = 2'h0,
    VAR_MID  = 2'h1,
    VAR_HIGH = 2'h2
  } drce_variant_e;

  typedef enum logic [3:0] {
    ST_LOAD = 4'h1,
    ST_MEAS = 4'h2,
    ST_CAL  = 4'h4,
    ST_SET  = 4'h8
  } drce_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned GATE_TIME_MS    = 1000;
  localparam int unsigned GATE_CYCLES_DEF = GATE_TIME_MS * 1000000 / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Factors in hundredths
  localparam logic [7:0] FACTOR_MIN  = 8'h3C;
  localparam logic [7:0] FACTOR_MAX  = 8'h8C;
  localparam logic [7:0] FACTOR_RST  = 8'h64;
  localparam logic [7:0] FACTOR_STEP = 8'h01;

  // Factor labels shown on the display
  localparam logic [1:0] LBL_NONE    = 2'h0;
  localparam logic [1:0] LBL_SENS    = 2'h1;
  localparam logic [1:0] LBL_DT_LOW  = 2'h2;
  localparam logic [1:0] LBL_DT_HIGH = 2'h3;
  localparam logic [1:0] LOAD_LAST   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Reading arithmetic; readings are in thousandths of the display unit
  localparam logic [47:0] READ_MULT = 48'h00000000000A;
  localparam logic [47:0] DIV_LOW   = 48'h000000000011;
  localparam logic [47:0] DIV_MID   = 48'h00000000012C;
  localparam logic [47:0] DIV_HIGH  = 48'h00000000004D;
  localparam logic [47:0] DT_DIV    = 48'h000005F5E100;

  // Blend band start and width
  localparam logic [31:0] BLEND_LO_LOW    = 32'h000F4240;
  localparam logic [31:0] BLEND_SPAN_LOW  = 32'h00030D40;
  localparam logic [31:0] BLEND_LO_MID    = 32'h000493E0;
  localparam logic [31:0] BLEND_SPAN_MID  = 32'h000186A0;
  localparam logic [31:0] BLEND_LO_HIGH   = 32'h003567E0;
  localparam logic [31:0] BLEND_SPAN_HIGH = 32'h001E8480;

  // Field bounds that pick the editable factor
  localparam logic [31:0] SEL1_LOW  = 32'h000003E8;
  localparam logic [31:0] SEL2_LOW  = 32'h0000C350;
  localparam logic [31:0] SEL3_LOW  = 32'h0010C8E0;
  localparam logic [31:0] SEL1_MID  = 32'h0000000A;
  localparam logic [31:0] SEL2_MID  = 32'h0000C350;
  localparam logic [31:0] SEL3_MID  = 32'h00055730;
  localparam logic [31:0] SEL1_HIGH = 32'h000003E8;
  localparam logic [31:0] SEL2_HIGH = 32'h0007A120;
  localparam logic [31:0] SEL3_HIGH = 32'h005B8D80;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin bit positions and carriers
  localparam int IN_PULSE   = 0;
  localparam int IN_RESET   = 1;
  localparam int IN_SPEAKER = 2;
  localparam int IN_CAL     = 3;

  typedef struct packed {
    logic cal_sw;
    logic speaker_btn;
    logic reset_btn;
    logic pulse;
  } drce_pins_s;

  typedef struct packed {
    logic       rd_req;
    logic       we;
    logic [1:0] addr;
    logic [7:0] wdata;
  } drce_nvm_req_s;

  typedef struct packed {
    logic       rd_valid;
    logic [7:0] rd_data;
  } drce_nvm_rsp_s;

  typedef struct packed {
    logic        cal_ind;
    logic        set_mode;
    logic [1:0]  label;
    logic [7:0]  factor;
    logic [31:0] reading;
  } drce_disp_s;

endpackage

// *** testbench/drce_field_model.sv ***
// Detector pulse train and nonvolatile factor store
`timescale 1ns/1ps
`default_nettype none

module drce_field_model
  import drce_pkg::*;
#(
  parameter int unsigned PULSE_PERIOD = 10
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic [23:0]   preset,
  input  wire drce_nvm_req_s nvm_req,
  output drce_nvm_rsp_s      nvm_rsp,
  output logic               pulse,
  output logic [23:0]        mem_o
);
  int unsigned ph     = 0;
  logic        served = 1'h0;

  initial begin
    nvm_rsp = '0;
    pulse   = 1'h0;
    mem_o   = '0;
  end

  always @(posedge sys_clk) begin
    #1;
    ph = (ph + 1) % PULSE_PERIOD;
    pulse = (ph < PULSE_PERIOD / 2);
    if (!rstn) mem_o = preset;
    if (nvm_req.we) mem_o[nvm_req.addr * 8 +: 8] = nvm_req.wdata;
    // One word per request, then the data line drifts
    if (nvm_req.rd_req && !served) begin
      nvm_rsp = {1'h1, mem_o[nvm_req.addr * 8 +: 8]};
      served = 1'h1;
    end else begin
      nvm_rsp = {1'h0, ~nvm_rsp.rd_data};
      served = served && nvm_req.rd_req;
    end
  end
endmodule

`default_nettype wire

// *** testbench/drce_sva.sv ***
// Port property checker of the dose rate calibration engine
`timescale 1ns/1ps
`default_nettype none

module drce_sva
  import drce_pkg::*;
#(
  parameter drce_variant_e VARIANT     = VAR_LOW,
  parameter int unsigned   GATE_CYCLES = GATE_CYCLES_DEF
) (
  input wire logic          sys_clk,
  input wire logic          rstn,
  input wire drce_pins_s    pins_i,
  input wire drce_nvm_rsp_s nvm_i,
  input wire drce_nvm_req_s nvm_o,
  input wire drce_disp_s    disp_o
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  logic [31:0] since_r;
  logic        seen_r;

  // Cycles since the reading last moved
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      since_r <= '0;
      seen_r  <= 1'h0;
    end else begin
      since_r <= $changed(disp_o.reading) ? 32'h0 : since_r + 32'h1;
      seen_r  <= seen_r | $changed(disp_o.reading);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    nvm_o.rd_req && nvm_i.rd_valid;
  endsequence
  sequence s_sw_on;
    pins_i.cal_sw [*8];
  endsequence
  sequence s_sw_off;
    (!pins_i.cal_sw) [*8];
  endsequence

  AST_TAKE_DROP: assert property (s_take |-> ##[1:2] !nvm_o.rd_req)
    else $error("load request held after word taken");
  AST_GATE_PHASE: assert property ((seen_r && $changed(disp_o.reading)) |->
    ((since_r + 32'h1) % GATE_CYCLES == 0))
    else $error("reading moved off the gate boundary");
  AST_FACTOR_RANGE: assert property ((disp_o.label != LBL_NONE) |->
    (disp_o.factor >= FACTOR_MIN && disp_o.factor <= FACTOR_MAX))
    else $error("shown factor out of range");
  AST_WDATA_RANGE: assert property (nvm_o.we |-> (nvm_o.addr <= 2'h2 &&
    nvm_o.wdata >= FACTOR_MIN && nvm_o.wdata <= FACTOR_MAX))
    else $error("stored factor out of range");
  AST_WE_SINGLE: assert property (nvm_o.we |=> !nvm_o.we)
    else $error("write strobe longer than one cycle");
  AST_WE_IN_SET: assert property (nvm_o.we |-> (disp_o.set_mode && disp_o.cal_ind))
    else $error("write outside factor setting");
  AST_SET_IN_CAL: assert property (disp_o.set_mode |-> disp_o.cal_ind)
    else $error("setting shown without calibration indication");
  AST_CAL_ENTER: assert property (s_sw_on |-> disp_o.cal_ind)
    else $error("calibration not entered");
  AST_CAL_EXIT: assert property (s_sw_off |-> (!disp_o.cal_ind && !disp_o.set_mode))
    else $error("calibration not left");
  AST_STEP_ONE: assert property ((disp_o.set_mode && $past(disp_o.set_mode) &&
    $stable(disp_o.label) && $changed(disp_o.factor)) |->
    (disp_o.factor == $past(disp_o.factor) + 8'h01 || disp_o.factor + 8'h01 == $past(disp_o.factor)))
    else $error("factor moved by more than one step");
  AST_LABEL_ZERO: assert property ((disp_o.label == LBL_NONE) |-> (disp_o.factor == 8'h00))
    else $error("factor shown without label");
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench of the engine in all three variants
`timescale 1ns/1ps
`default_nettype none

module testbench
  import drce_pkg::*;
;

  localparam int unsigned GC   = 200;
  localparam int unsigned NPUL = GC / 10;
  localparam int unsigned RUN  = 10 * GC + 2000;

  logic          sys_clk  = 1'h0;
  logic          rstn     = 1'h0;
  logic          cal_sw   = 1'h0;
  logic          rst_btn  = 1'h0;
  logic          spk_btn  = 1'h0;
  logic [23:0]   preset   = 24'h000000;
  logic [15:0]   lfsr     = 16'h001E;
  logic          pulse;
  logic [23:0]   mem;
  drce_pins_s    pins;
  drce_nvm_rsp_s nvm_rsp;
  drce_nvm_req_s nvm_req [3];
  drce_disp_s    disp [3];
  logic [7:0]    fac [4];
  int            sel [3];
  int            errors   = 0;
  int            compares = 0;
  int            we_cnt   = 0;
  int            sens_init;
  int            f;
  logic          up;

  assign pins = {cal_sw, spk_btn, rst_btn, pulse};
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk)
    if (nvm_req[0].we === 1'h1) we_cnt++;

  for (genvar i = 0; i < 3; i++) begin : g_var
    drce_engine #(
      .VARIANT     (drce_variant_e'(i)),
      .GATE_CYCLES (GC)
    ) uut (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pins_i  (pins),
      .nvm_i   (nvm_rsp),
      .nvm_o   (nvm_req[i]),
      .disp_o  (disp[i])
    );
  end

  drce_field_model u_field (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .preset  (preset),
    .nvm_req (nvm_req[0]),
    .nvm_rsp (nvm_rsp),
    .pulse   (pulse),
    .mem_o   (mem)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] exp_read(input int v, input int fs);
    int dtc;
    dtc = (NPUL * FACTOR_MIN) * (NPUL * FACTOR_MIN) / 100000000;
    return (NPUL * fs + dtc) * 10 / ((v == 0) ? 17 : ((v == 1) ? 300 : 77));
  endfunction

  function automatic int lbl_of(input int v, input logic [31:0] rd);
    return (rd > ((v == 1) ? 10 : 1000)) ? 1 : 0;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic press(input logic [1:0] m);
    {spk_btn, rst_btn} = m;
    step(8);
    {spk_btn, rst_btn} = 2'h0;
    step(8);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    lfsr = lfsr_next(lfsr);
    sens_init = 92 + lfsr % 49;
    preset = {8'hFF, 8'h00, sens_init[7:0]};
    fac = '{8'h00, sens_init[7:0], FACTOR_MIN, FACTOR_MAX};
    step(8);
    rstn = 1'h1;
    step(3 * GC + 20);
    for (int i = 0; i < 3; i++) begin
      sel[i] = lbl_of(i, exp_read(i, sens_init));
      chk("reading", disp[i].reading, exp_read(i, sens_init));
    end
    cal_sw = 1'h1;
    step(10);
    for (int i = 0; i < 3; i++) chk("cal_ind", disp[i].cal_ind, 1);
    for (int k = 1; k <= 4; k++) begin
      press(2'h1);
      for (int i = 0; i < 3; i++) chk("label", disp[i].label, k % 4);
      for (int i = 0; i < 3; i++) chk("factor", disp[i].factor, fac[k % 4]);
    end
    rst_btn = 1'h1;
    step(8);
    spk_btn = 1'h1;
    step(8);
    {spk_btn, rst_btn} = 2'h0;
    step(8);
    for (int i = 0; i < 3; i++) chk("set_mode", disp[i].set_mode, 1);
    for (int i = 0; i < 3; i++) chk("label", disp[i].label, sel[i]);
    f = sens_init;
    for (int j = 0; j < 88; j++) begin
      lfsr = lfsr_next(lfsr);
      up = (j >= 6 && j < 87) || (j < 6 && lfsr[0]);
      press(up ? 2'h1 : 2'h2);
      f = up ? ((f < 140) ? f + 1 : 140) : ((f > 60) ? f - 1 : 60);
      for (int i = 0; i < 3; i++) chk("factor", disp[i].factor, sel[i] ? f : 0);
    end
    chk("writes", we_cnt, 88);
    chk("stored", mem[7:0], f);
    cal_sw = 1'h0;
    step(10);
    for (int i = 0; i < 3; i++) chk("cal_ind", disp[i].cal_ind, 0);
    step(3 * GC);
    for (int i = 0; i < 3; i++) begin
      chk("reading", disp[i].reading, exp_read(i, sel[i] ? f : sens_init));
    end
    stop_test();
  end

  initial begin
    repeat (RUN) @(posedge sys_clk);
    errors++;
    stop_test();
  end
endmodule

bind drce_engine drce_sva #(
  .VARIANT     (VARIANT),
  .GATE_CYCLES (GATE_CYCLES)
) u_sva (
  .sys_clk (sys_clk),
  .rstn    (rstn),
  .pins_i  (pins_i),
  .nvm_i   (nvm_i),
  .nvm_o   (nvm_o),
  .disp_o  (disp_o)
);

`default_nettype wire
